/* File: hw/mgmt_regs_pkg.sv */
// constants, field layouts and carriers for the management register bank
// assumes one 25 MHz clock and already-decoded management transactions
package mgmt_regs_pkg;

    // -------------------------------------------------------------
    // register indices
    // -------------------------------------------------------------
    localparam logic [4:0] REG_CTRL = 5'h00;
    localparam logic [4:0] REG_STAT = 5'h01;
    localparam logic [4:0] REG_MODE = 5'h11;
    localparam logic [4:0] REG_SYMERR = 5'h1a;
    localparam logic [4:0] REG_EVT = 5'h1d;
    localparam logic [4:0] REG_TEST = 5'h1e;

    // -------------------------------------------------------------
    // field positions
    // -------------------------------------------------------------
    localparam int CTRL_SOFT_RESET = 15;
    localparam int CTRL_LOOPBACK = 14;
    localparam int CTRL_ISOLATE = 10;
    localparam int CTRL_RESTART_AN = 9;
    localparam int STAT_REMOTE_FAULT = 4;
    localparam int STAT_LINK = 2;
    localparam int MODE_LINE_LOOPBACK = 9;
    localparam int MODE_KEPT = 6;
    localparam int EVT_WRITE_ONE_CLEAR = 0;
    localparam int EVT_WRITE_ANY_CLEAR = 1;
    localparam int TEST_STROBE_BIT = 15;
    localparam int TEST_SELF_SET = 0;

    // -------------------------------------------------------------
    // values after reset
    // -------------------------------------------------------------
    localparam logic [15:0] STAT_ABILITY = 16'h7808;
    localparam logic RST_KEPT = 1'b0;
    localparam logic RST_SELF_SET = 1'b1;
    localparam logic [15:0] RST_SYMERR = 16'h0000;

    // -------------------------------------------------------------
    // carriers
    // -------------------------------------------------------------
    typedef struct packed {
        logic req;
        logic we;
        logic [4:0] addr;
        logic [15:0] wdata;
    } mgmt_req_s;

    typedef struct packed {
        logic dv;
        logic [1:0] d;
    } lane_s;

endpackage

/* File: hw/mgmt_regs.sv */
// management register bank with line-side loopback datapath
// assumes management transactions arrive decoded, one request per cycle
module mgmt_regs (
    input wire logic CLK,
    input wire logic RST,
    input wire mgmt_regs_pkg::mgmt_req_s MGMT_REQ,
    output logic [15:0] MGMT_RDATA,
    output logic MGMT_ACK,
    input wire logic REMOTE_FAULT_IN,
    input wire logic LINK_UP_IN,
    input wire logic SYM_ERR_IN,
    input wire logic [1:0] EVENT_IN,
    input wire mgmt_regs_pkg::lane_s LINE_RX,
    output mgmt_regs_pkg::lane_s LINE_TX,
    input wire mgmt_regs_pkg::lane_s MAC_TX,
    output mgmt_regs_pkg::lane_s MAC_RX,
    output logic SOFT_RESET,
    output logic AN_RESTART,
    output logic NEAR_LOOPBACK,
    output logic TEST_STROBE,
    output logic LOOPBACK_ACTIVE
);
    import mgmt_regs_pkg::*;

    // -------------------------------------------------------------
    // state
    // -------------------------------------------------------------
    logic srst_q, restart_q, lpbk_q, isolate_q, loop_q, kept_q;
    logic latched_high_q, latched_low_q, woc_q, ss_q, strobe_q;
    logic write_any_clear_q;
    logic [15:0] cnt_q, cnt_d, rdata_q;
    logic ack_q;
    lane_s line_tx_q, mac_rx_q;

    // -------------------------------------------------------------
    // access decode
    // -------------------------------------------------------------
    logic wr, rd, wr_ctrl, wr_mode, wr_evt, wr_test;
    logic rd_stat, rd_symerr;
    logic [15:0] wd, rmux;
    assign wd = MGMT_REQ.wdata;
    assign wr = MGMT_REQ.req & MGMT_REQ.we;
    assign rd = MGMT_REQ.req & ~MGMT_REQ.we;
    assign wr_ctrl = wr && MGMT_REQ.addr == REG_CTRL;
    assign wr_mode = wr && MGMT_REQ.addr == REG_MODE;
    assign wr_evt = wr && MGMT_REQ.addr == REG_EVT;
    assign wr_test = wr && MGMT_REQ.addr == REG_TEST;
    assign rd_stat = rd && MGMT_REQ.addr == REG_STAT;
    assign rd_symerr = rd && MGMT_REQ.addr == REG_SYMERR;

    // -------------------------------------------------------------
    // read mux, reserved bits read zero
    // -------------------------------------------------------------
    logic [15:0] v_ctrl, v_stat, v_mode, v_evt, v_test;
    assign v_ctrl = (16'(srst_q) << CTRL_SOFT_RESET)
        | (16'(lpbk_q) << CTRL_LOOPBACK)
        | (16'(isolate_q) << CTRL_ISOLATE)
        | (16'(restart_q) << CTRL_RESTART_AN);
    assign v_stat = STAT_ABILITY
        | (16'(latched_high_q) << STAT_REMOTE_FAULT)
        | (16'(latched_low_q) << STAT_LINK);
    assign v_mode = (16'(loop_q) << MODE_LINE_LOOPBACK)
        | (16'(kept_q) << MODE_KEPT);
    assign v_evt = (16'(woc_q) << EVT_WRITE_ONE_CLEAR)
        | (16'(write_any_clear_q) << EVT_WRITE_ANY_CLEAR);
    assign v_test = 16'(ss_q) << TEST_SELF_SET;
    always_comb begin
        case (MGMT_REQ.addr)
            REG_CTRL: rmux = v_ctrl;
            REG_STAT: rmux = v_stat;
            REG_MODE: rmux = v_mode;
            REG_SYMERR: rmux = cnt_q;
            REG_EVT: rmux = v_evt;
            REG_TEST: rmux = v_test;
            default: rmux = 16'h0000;
        endcase
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            rdata_q <= 16'h0000;
            ack_q <= 1'b0;
        end else begin
            ack_q <= MGMT_REQ.req;
            if (rd) begin
                rdata_q <= rmux;
            end
        end
    end

    // -------------------------------------------------------------
    // control bits, soft reset
    // -------------------------------------------------------------
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            srst_q <= 1'b0;
            restart_q <= 1'b0;
            lpbk_q <= 1'b0;
            isolate_q <= 1'b0;
            loop_q <= 1'b0;
            strobe_q <= 1'b0;
        end else if (srst_q) begin
            srst_q <= 1'b0;
            restart_q <= 1'b0;
            lpbk_q <= 1'b0;
            isolate_q <= 1'b0;
            loop_q <= 1'b0;
            strobe_q <= 1'b0;
        end else begin
            srst_q <= wr_ctrl & wd[CTRL_SOFT_RESET];
            restart_q <= wr_ctrl & wd[CTRL_RESTART_AN];
            strobe_q <= wr_test & wd[TEST_STROBE_BIT];
            if (wr_ctrl) begin
                lpbk_q <= wd[CTRL_LOOPBACK];
                isolate_q <= wd[CTRL_ISOLATE];
            end
            if (wr_mode) begin
                loop_q <= wd[MODE_LINE_LOOPBACK];
            end
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            kept_q <= RST_KEPT;
        end else if (wr_mode && !srst_q) begin
            kept_q <= wd[MODE_KEPT];
        end
    end

    // -------------------------------------------------------------
    // status latches, flags, counter
    // -------------------------------------------------------------
    assign cnt_d = rd_symerr ? 16'(SYM_ERR_IN)
        : cnt_q + 16'(SYM_ERR_IN && cnt_q != 16'hffff);

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            latched_high_q <= 1'b0;
            latched_low_q <= 1'b0;
            woc_q <= 1'b0;
            write_any_clear_q <= 1'b0;
            ss_q <= RST_SELF_SET;
            cnt_q <= RST_SYMERR;
        end else if (srst_q) begin
            latched_high_q <= 1'b0;
            latched_low_q <= 1'b0;
            woc_q <= 1'b0;
            write_any_clear_q <= 1'b0;
            ss_q <= RST_SELF_SET;
            cnt_q <= RST_SYMERR;
        end else begin
            latched_high_q <= REMOTE_FAULT_IN
                | (latched_high_q & ~rd_stat);
            latched_low_q <= LINK_UP_IN & (latched_low_q | rd_stat);
            woc_q <= EVENT_IN[0]
                | (woc_q & ~(wr_evt & wd[EVT_WRITE_ONE_CLEAR]));
            write_any_clear_q <= EVENT_IN[1]
                | (write_any_clear_q & ~wr_evt);
            ss_q <= ~(wr_test & ~wd[TEST_SELF_SET]);
            cnt_q <= cnt_d;
        end
    end

    // -------------------------------------------------------------
    // data path
    // -------------------------------------------------------------
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            line_tx_q <= '0;
            mac_rx_q <= '0;
        end else if (loop_q) begin
            line_tx_q <= LINE_RX;
            mac_rx_q <= '0;
        end else begin
            line_tx_q <= isolate_q ? '0 : MAC_TX;
            mac_rx_q <= isolate_q ? '0 : LINE_RX;
        end
    end

    assign MGMT_RDATA = rdata_q;
    assign MGMT_ACK = ack_q;
    assign LINE_TX = line_tx_q;
    assign MAC_RX = mac_rx_q;
    assign SOFT_RESET = srst_q;
    assign AN_RESTART = restart_q;
    assign NEAR_LOOPBACK = lpbk_q;
    assign TEST_STROBE = strobe_q;
    assign LOOPBACK_ACTIVE = loop_q;

    // -------------------------------------------------------------
    // checks
    // -------------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    sequence s_self_clearing_pulse;
        srst_q ##1 !srst_q;
    endsequence
    sequence s_ss_back;
        !ss_q ##1 ss_q;
    endsequence

    property p_loop_enter;
        wr_mode && !srst_q |=> loop_q == $past(wd[MODE_LINE_LOOPBACK]);
    endproperty
    a_loop_enter: assert property (p_loop_enter)
        else $error("loopback enable not followed");

    property p_loop_fwd;
        loop_q |=> LINE_TX == $past(LINE_RX);
    endproperty
    a_loop_fwd: assert property (p_loop_fwd)
        else $error("line data not looped back");

    property p_mac_quiet;
        loop_q |=> MAC_RX == '0;
    endproperty
    a_mac_quiet: assert property (p_mac_quiet)
        else $error("mac receive active in loopback");

    property p_rd_mode;
        rd && MGMT_REQ.addr == REG_MODE
            |=> MGMT_ACK && MGMT_RDATA[MODE_LINE_LOOPBACK] == $past(loop_q);
    endproperty
    a_rd_mode: assert property (p_rd_mode)
        else $error("mode register read wrong");

    property p_wo_read;
        rd && MGMT_REQ.addr == REG_TEST |=> !MGMT_RDATA[TEST_STROBE_BIT];
    endproperty
    a_wo_read: assert property (p_wo_read)
        else $error("write-only bit reads nonzero");

    property p_woc;
        wr_evt && wd[EVT_WRITE_ONE_CLEAR] && !EVENT_IN[0] && !srst_q
            |=> !woc_q;
    endproperty
    a_woc: assert property (p_woc)
        else $error("write-one-clear flag not cleared");

    property p_woc_keep;
        woc_q && wr_evt && !wd[EVT_WRITE_ONE_CLEAR] && !srst_q |=> woc_q;
    endproperty
    a_woc_keep: assert property (p_woc_keep)
        else $error("write of zero cleared flag");

    property p_write_any_clear;
        wr_evt && !EVENT_IN[1] && !srst_q |=> !write_any_clear_q;
    endproperty
    a_write_any_clear: assert property (p_write_any_clear)
        else $error("write-any-clear flag survived write");

    property p_cor;
        rd_symerr && !srst_q ##1 MGMT_ACK |-> MGMT_RDATA == $past(cnt_q)
            && cnt_q <= 16'h0001;
    endproperty
    a_cor: assert property (p_cor)
        else $error("counter not cleared on read");

    property p_latched_low_hold;
        !latched_low_q && !rd_stat |=> !latched_low_q;
    endproperty
    a_latched_low_hold: assert property (p_latched_low_hold)
        else $error("latched low released without read");

    property p_latched_high_hold;
        latched_high_q && !rd_stat && !srst_q |=> latched_high_q [*2] or
            (latched_high_q ##1 (rd_stat || srst_q));
    endproperty
    a_latched_high_hold: assert property (p_latched_high_hold)
        else $error("latched high released without read");

    property p_latched_high_follow;
        rd_stat && !srst_q |=> latched_high_q == $past(REMOTE_FAULT_IN);
    endproperty
    a_latched_high_follow: assert property (p_latched_high_follow)
        else $error("latched high not following after read");

    property p_self_clearing;
        wr_ctrl && wd[CTRL_SOFT_RESET] && !srst_q |=> s_self_clearing_pulse;
    endproperty
    a_self_clearing: assert property (p_self_clearing)
        else $error("self-clearing bit stuck");

    property p_ss;
        wr_test && !wd[TEST_SELF_SET] && !srst_q |=> s_ss_back;
    endproperty
    a_ss: assert property (p_ss)
        else $error("self-setting bit not restored");

    property p_kept;
        srst_q |=> kept_q == $past(kept_q) && !loop_q && !lpbk_q;
    endproperty
    a_kept: assert property (p_kept)
        else $error("soft reset handled kept bits wrongly");

endmodule

/* File: verif/mgmt_ctl.sv */
// station management controller model driving decoded requests
// assumes requests are launched at the falling edge, one per call
module mgmt_ctl (
    input wire logic CLK,
    output mgmt_regs_pkg::mgmt_req_s REQ
);
    timeunit 1ns;
    timeprecision 1ns;
    import mgmt_regs_pkg::*;

    // ----------------------------------------------------------
    // request tasks
    // ----------------------------------------------------------
    initial REQ = '0;

    // control bits 7:0 are always sent as zero; reserved bits 13:11 and 8 pass through
    task go(input logic we, input logic [4:0] addr, input logic [15:0] data);
        logic [15:0] keep;
        keep = (addr == REG_CTRL) ? 16'hff00 : 16'hffff;
        @(negedge CLK);
        REQ <= '{req: 1'b1, we: we, addr: addr, wdata: data & keep};
    endtask

    // idle fields show the inverse of the last value, not stale data
    task idle();
        @(negedge CLK);
        REQ <= '{req: 1'b0, we: ~REQ.we, addr: ~REQ.addr, wdata: ~REQ.wdata};
    endtask
endmodule

/* File: verif/phy_mgmt_register_semantics_tb_top.sv */
// self-checking bench for the management register bank
// assumes the controller model and a single 25 MHz clock
module phy_mgmt_register_semantics_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import mgmt_regs_pkg::*;

    // ----------------------------------------------------------
    // signals
    // ----------------------------------------------------------
    logic clk = 1'b0;
    logic rst = 1'b1;
    mgmt_req_s req;
    logic [15:0] rdata;
    logic ack, rf, lk, se, srst, anr, nlb, tst, lpa, dp_on;
    logic [1:0] ev;
    lane_s lrx, ltx, mtx, mrx;
    int fails = 0;
    int checks_done = 0;
    int n;
    logic [22:0] q[$];
    logic [2:0] lvl, vis;
    logic [31:0] seed = 32'h00000063;

    always #20 clk = ~clk;

    mgmt_ctl ctl_u (.CLK(clk), .REQ(req));

    mgmt_regs dut_u (
        .CLK(clk), .RST(rst), .MGMT_REQ(req), .MGMT_RDATA(rdata),
        .MGMT_ACK(ack), .REMOTE_FAULT_IN(rf), .LINK_UP_IN(lk),
        .SYM_ERR_IN(se), .EVENT_IN(ev), .LINE_RX(lrx), .LINE_TX(ltx),
        .MAC_TX(mtx), .MAC_RX(mrx), .SOFT_RESET(srst), .AN_RESTART(anr),
        .NEAR_LOOPBACK(nlb), .TEST_STROBE(tst), .LOOPBACK_ACTIVE(lpa)
    );

    // ----------------------------------------------------------
    // helpers
    // ----------------------------------------------------------
    function logic [31:0] nxt();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task chk(input string nm, input logic [15:0] e, input logic [15:0] s);
        checks_done++;
        if (e !== s) begin
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
            fails++;
        end
    endtask

    // note {read, data, pulses soft/an/strobe, levels iso/near/loop}
    task rd(input logic [4:0] a, input logic [15:0] e);
        q.push_back({1'b1, e, 3'b000, lvl});
        ctl_u.go(1'b0, a, 16'h0000);
    endtask

    task wr(input logic [4:0] a, input logic [15:0] d, input logic [2:0] p);
        q.push_back({1'b0, 16'h0000, p, lvl});
        ctl_u.go(1'b1, a, d);
    endtask

    task wait_n(input int k);
        repeat (k) ctl_u.idle();
    endtask

    task summarize();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // ----------------------------------------------------------
    // random line and mac traffic
    // ----------------------------------------------------------
    always @(negedge clk) begin
        logic [31:0] r;
        r = nxt();
        lrx <= r[2:0];
        mtx <= r[10:8];
    end

    // ----------------------------------------------------------
    // monitor: datapath every cycle, oldest note on each ack
    // ----------------------------------------------------------
    always @(negedge clk) begin
        logic [22:0] e;
        if (!rst && dp_on) begin
            chk("line_tx", vis[0] ? lrx : (vis[2] ? 3'b000 : mtx), ltx);
            chk("mac_rx", (vis[0] | vis[2]) ? 3'b000 : lrx, mrx);
        end
        if (ack === 1'b1) begin
            if (q.size() == 0) begin
                $display("MISMATCH ack expected 0 seen 1");
                fails++;
            end else begin
                e = q.pop_front();
                if (e[22])
                    chk("rdata", e[21:6], rdata);
                chk("pulses", e[5:3], {srst, anr, tst});
                chk("levels", e[1:0], {nlb, lpa});
                vis = e[2:0];
            end
        end
    end

    // ----------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------
    initial begin
        rf = 1'b0; lk = 1'b1; se = 1'b0; ev = 2'b00;
        lrx = '0; mtx = '0; lvl = 3'b000; vis = 3'b000; dp_on = 1'b0;
        repeat (6) @(negedge clk);
        rst <= 1'b0;
        dp_on <= 1'b1;
        rd(REG_CTRL, 16'h0000);
        rd(REG_MODE, 16'h0000);
        rd(REG_TEST, 16'h0001);
        rd(5'h05, 16'h0000);
        rd(REG_STAT, STAT_ABILITY);
        rd(REG_STAT, STAT_ABILITY | 16'h0004);
        ctl_u.idle();
        lk <= 1'b0;
        ctl_u.idle();
        lk <= 1'b1;
        wait_n(3);
        rd(REG_STAT, STAT_ABILITY);
        rd(REG_STAT, STAT_ABILITY | 16'h0004);
        ctl_u.idle();
        rf <= 1'b1;
        ctl_u.idle();
        rf <= 1'b0;
        wait_n(2);
        rd(REG_STAT, STAT_ABILITY | 16'h0014);
        rd(REG_STAT, STAT_ABILITY | 16'h0004);
        ctl_u.idle();
        rf <= 1'b1;
        ctl_u.idle();
        rd(REG_STAT, STAT_ABILITY | 16'h0014);
        rd(REG_STAT, STAT_ABILITY | 16'h0014);
        ctl_u.idle();
        rf <= 1'b0;
        ctl_u.idle();
        rd(REG_STAT, STAT_ABILITY | 16'h0014);
        rd(REG_STAT, STAT_ABILITY | 16'h0004);
        wr(REG_STAT, 16'hff3f, 3'b000);
        rd(REG_STAT, STAT_ABILITY | 16'h0004);
        n = int'(nxt() % 32'd7) + 1;
        repeat (n) begin
            ctl_u.idle();
            se <= 1'b1;
        end
        ctl_u.idle();
        se <= 1'b0;
        wr(REG_SYMERR, 16'h0000, 3'b000);
        rd(REG_SYMERR, n[15:0]);
        rd(REG_SYMERR, 16'h0000);
        ctl_u.idle();
        ev <= 2'b11;
        ctl_u.idle();
        ev <= 2'b00;
        rd(REG_EVT, 16'h0003);
        wr(REG_EVT, 16'h0000, 3'b000);
        rd(REG_EVT, 16'h0001);
        wr(REG_EVT, 16'h0001, 3'b000);
        rd(REG_EVT, 16'h0000);
        wr(REG_TEST, 16'h8001, 3'b001);
        rd(REG_TEST, 16'h0001);
        wr(REG_TEST, 16'h0000, 3'b000);
        rd(REG_TEST, 16'h0000);
        rd(REG_TEST, 16'h0001);
        wr(REG_CTRL, 16'h0200, 3'b010);
        rd(REG_CTRL, 16'h0200);
        rd(REG_CTRL, 16'h0000);
        lvl = 3'b100;
        wr(REG_CTRL, 16'h0400, 3'b000);
        wait_n(8);
        lvl = 3'b001;
        wr(REG_MODE, 16'h0200, 3'b000);
        wait_n(8);
        lvl = 3'b011;
        wr(REG_CTRL, 16'h4000, 3'b000);
        rd(REG_MODE, 16'h0200);
        wait_n(8);
        lvl = 3'b001;
        wr(REG_CTRL, 16'h0000, 3'b000);
        lvl = 3'b000;
        wr(REG_MODE, 16'h0000, 3'b000);
        wait_n(8);
        lvl = 3'b001;
        wr(REG_MODE, 16'h0240, 3'b000);
        ctl_u.idle();
        ev <= 2'b11;
        ctl_u.idle();
        ev <= 2'b00;
        dp_on <= 1'b0;
        wr(REG_CTRL, 16'h8000, 3'b100);
        wait_n(2);
        lvl = 3'b000;
        rd(REG_MODE, 16'h0040);
        rd(REG_EVT, 16'h0000);
        rd(REG_CTRL, 16'h0000);
        for (int i = 0; i < 20 && q.size() != 0; i++)
            ctl_u.idle();
        if (q.size() != 0) begin
            $display("MISMATCH pending_acks expected 0 seen %0d", q.size());
            fails++;
        end
        summarize();
    end
endmodule
